// ---- core/ssr_state_file.sv ----
// Vector state register file with fast save/restore, reached over AXI4-Lite
// Contract
// - Save/restore covers wide, control, scalar, narrow state
// - Narrow registers alias scalar data registers
// - Leaf 1 D-result bit 24 reports fast save
// - First-extension bit independent of fast-save bit
// - Leaf 1 D-result bit 26 reports second extension
// - Second extension adds no state of its own
// - Eight 128-bit wide vector registers
// - Scalar double operand is wide low quadword
// - Packed double: two binary64 halves per register
// - Wide register readable as byte/word/dword/qword lanes
// - 32-bit control/status with DAZ and FTZ
// - Eight 64-bit narrow vector registers
// - Addresses formed from general registers only
// - Some vector compares update processor flags
// - Second extension enabled in every operating mode
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssr_state_file #(
  parameter bit HAS_FAST_SAVE = 1'b1,
  parameter bit HAS_VEC1      = 1'b1,
  parameter bit HAS_VEC2      = 1'b1
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [ssr_pkg::WIDE_BITS-1:0] scalar_op_ff,
  output logic                        busy_ff
);
  import ssr_pkg::*;

  // Register storage
  logic [WIDE_BITS-1:0]   wide_ff  [VEC_COUNT];   // Wide vector regs
  logic [SCALAR_BITS-1:0] scal_ff  [VEC_COUNT];   // Scalar FP data registers
  logic [WIDE_BITS-1:0]   shw_ff   [VEC_COUNT];   // Save image, wide part
  logic [SCALAR_BITS-1:0] shs_ff   [VEC_COUNT];   // Save image, scalar part
  logic [31:0]            vcsr_ff;                // Vector control/status
  logic [31:0]            shv_ff;                 // Save image, control word
  logic [31:0]            flags_ff;               // Processor flags
  logic [31:0]            leaf_ff;                // Id query leaf
  logic [31:0]            sel_ff;                 // Data window select
  logic [31:0]            base_ff;                // General base register
  logic [31:0]            idx_ff;                 // General index register
  logic [31:0]            addr_ff;                // Formed address
  logic [2:0]             cnt_ff;                 // Save/restore step
  ssr_state_type          st_ff;                  // Sequencer state

  // Bus holding registers
  logic        aw_ok_ff;          // Write address latched
  logic        w_ok_ff;           // Write data latched
  logic [11:0] awa_ff;            // Latched write address
  logic [31:0] wd_ff;             // Latched write data
  logic [3:0]  ws_ff;             // Latched strobes
  logic        wr_go;             // Both halves present
  logic        rd_go;             // Read accepted
  logic [31:0] wmerged;           // Strobe-merged write word
  logic [31:0] rd_word;           // Decoded read word
  logic        rd_hit;            // Read address mapped
  logic        wr_hit;            // Write address mapped

  // Select fields
  logic [2:0]  sel_reg;
  logic [1:0]  sel_word;
  logic [1:0]  sel_bank;
  assign sel_reg  = sel_ff[2:0];
  assign sel_bank = sel_ff[5:4];
  assign sel_word = sel_ff[9:8];

  assign wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Byte-lane merge; used by control, control/status, flags and software regs, not the data window
  always_comb begin
    wmerged = ZERO_WORD;
    for (int b = 0; b < 4; b++) begin
      wmerged[8*b +: 8] = ws_ff[b] ? wd_ff[8*b +: 8] : ZERO_WORD[7:0];
    end
  end

  // Write address channel: accept once, hold until response issued
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      awa_ff   <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_ff <= 1'b1;
      awa_ff   <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ok_ff <= 1'b0;
    end
  end

  // Write data channel, independent of address order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ok_ff <= 1'b0;
      wd_ff   <= ZERO_WORD;
      ws_ff   <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ok_ff <= 1'b1;
      wd_ff   <= s_axi_wdata;
      ws_ff   <= s_axi_wstrb;
    end else if (wr_go) begin
      w_ok_ff <= 1'b0;
    end
  end

  // Ready flags registered so outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Refused while a response is pending, so one write at a time
      s_axi_awready <= !aw_ok_ff && !s_axi_bvalid
                       && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_ok_ff && !s_axi_bvalid
                       && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write address decode; image area is read-only
  always_comb begin
    unique case (awa_ff)
      OFS_CTRL, OFS_VCSR, OFS_FLAGS, OFS_IDQ_LEAF, OFS_SEL, OFS_DATA,
      OFS_ADDR_BASE, OFS_ADDR_IDX: wr_hit = 1'b1;
      default:                     wr_hit = 1'b0;
    endcase
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Save/restore sequencer: one register pair per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff   <= SSR_IDLE;
      cnt_ff  <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        SSR_IDLE: begin
          cnt_ff <= 3'h0;
          if (wr_go && awa_ff == OFS_CTRL && wmerged[CTRL_SAVE]) begin
            st_ff   <= SSR_SAVE;
            busy_ff <= 1'b1;
          end else if (wr_go && awa_ff == OFS_CTRL
                       && wmerged[CTRL_RESTORE]) begin
            st_ff   <= SSR_RESTORE;
            busy_ff <= 1'b1;
          end
        end
        SSR_SAVE, SSR_RESTORE: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == 3'(VEC_COUNT - 1)) begin
            st_ff   <= SSR_IDLE;
            busy_ff <= 1'b0;
          end
        end
        default: begin
          st_ff   <= SSR_IDLE;                     // Illegal code recovers
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // Save image: wide, scalar (thus narrow) and control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shv_ff <= VCSR_RESET;
    end else if (st_ff == SSR_SAVE) begin
      shw_ff[cnt_ff] <= wide_ff[cnt_ff];
      shs_ff[cnt_ff] <= scal_ff[cnt_ff];
      if (cnt_ff == 3'h0) begin
        shv_ff <= vcsr_ff;
      end
    end
  end

  // Wide registers: written from bus window or restored from image
  always_ff @(posedge aclk) begin
    if (st_ff == SSR_RESTORE) begin
      wide_ff[cnt_ff] <= shw_ff[cnt_ff];
    end else if (wr_go && awa_ff == OFS_DATA && sel_bank == BANK_WIDE) begin
      // Any 32-bit lane addressable; byte lanes by strobe
      for (int b = 0; b < 4; b++) begin
        if (ws_ff[b]) begin
          wide_ff[sel_reg][32*sel_word + 8*b +: 8] <= wd_ff[8*b +: 8];
        end
      end
    end
  end

  // Scalar data registers; narrow view is their low 64 bits, no copy
  always_ff @(posedge aclk) begin
    if (st_ff == SSR_RESTORE) begin
      scal_ff[cnt_ff] <= shs_ff[cnt_ff];
    end else if (wr_go && awa_ff == OFS_DATA
                 && sel_bank == BANK_SCALAR && sel_word != 2'h3) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_ff[b] && (32*sel_word + 8*b) < SCALAR_BITS) begin
          scal_ff[sel_reg][32*sel_word + 8*b +: 8] <= wd_ff[8*b +: 8];
        end
      end
    end
  end

  // Control/status: DAZ, FTZ and the rest of the defined field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vcsr_ff <= VCSR_RESET;
    end else if (st_ff == SSR_RESTORE && cnt_ff == 3'h0) begin
      vcsr_ff <= shv_ff;
    end else if (wr_go && awa_ff == OFS_VCSR) begin
      vcsr_ff <= wmerged & VCSR_MASK;
    end
  end

  // Flags: compare outcome lands only on compare-affected bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= FLAGS_RESET;
    end else if (wr_go && awa_ff == OFS_FLAGS) begin
      flags_ff <= wmerged;
    end else if (wr_go && awa_ff == OFS_CTRL && wmerged[CTRL_CMPUPD]) begin
      // Compare low quadwords of regs 0 and 1 for equality
      flags_ff <= (flags_ff & ~FLAGS_CMP_MASK)
                | {25'h0, (wide_ff[0][63:0] == wide_ff[1][63:0]), 6'h0};
    end
  end

  // Plain software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      leaf_ff <= ZERO_WORD;
      sel_ff  <= ZERO_WORD;
      base_ff <= ZERO_WORD;
      idx_ff  <= ZERO_WORD;
    end else if (wr_go) begin
      if (awa_ff == OFS_IDQ_LEAF)  leaf_ff <= wmerged;
      if (awa_ff == OFS_SEL)       sel_ff  <= wmerged;
      if (awa_ff == OFS_ADDR_BASE) base_ff <= wmerged;
      if (awa_ff == OFS_ADDR_IDX)  idx_ff  <= wmerged;
    end
  end

  // Address generation sees general registers only, never vectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff <= ZERO_WORD;
    end else begin
      addr_ff <= base_ff + idx_ff;
    end
  end

  // Scalar operand path: low quadword, high half zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scalar_op_ff <= '0;
    end else begin
      scalar_op_ff <= {64'h0, wide_ff[sel_reg][63:0]};
    end
  end

  // Read decode; data window and save image by select
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = ZERO_WORD;
    if (s_axi_araddr[11:8] == OFS_SHADOW[11:8]) begin
      // Image readback: word sel_word of register sel_reg, or the control word for other banks
      unique case (sel_bank)
        BANK_WIDE:   rd_word = shw_ff[sel_reg][32*sel_word +: 32];
        BANK_SCALAR: rd_word = (sel_word == 2'h3) ? ZERO_WORD
          : WORD_BITS'({48'h0, shs_ff[sel_reg]} >> (32*sel_word));
        default:     rd_word = shv_ff;
      endcase
    end else begin
      unique case (s_axi_araddr)
        OFS_CTRL:      rd_word = ZERO_WORD;
        OFS_STATUS:    rd_word = {30'h0, st_ff == SSR_RESTORE,
                                  st_ff == SSR_SAVE};
        OFS_VCSR:      rd_word = vcsr_ff;
        OFS_FLAGS:     rd_word = flags_ff;
        OFS_IDQ_LEAF:  rd_word = leaf_ff;
        OFS_IDQ_D: begin
          if (leaf_ff == IDQ_LEAF_FEAT) begin
            // Independent capability bits
            rd_word[IDQ_FASTSAVE] = HAS_FAST_SAVE;
            rd_word[IDQ_VEC1]     = HAS_VEC1;
            rd_word[IDQ_VEC2]     = HAS_VEC2;
          end
        end
        OFS_SEL:       rd_word = sel_ff;
        OFS_DATA: begin
          // Scalar bank reads all 80 bits; words 0 and 1 are the narrow alias
          if (sel_bank == BANK_WIDE) begin
            rd_word = wide_ff[sel_reg][32*sel_word +: 32];
          end else if (sel_bank == BANK_SCALAR && sel_word != 2'h3) begin
            rd_word = WORD_BITS'({48'h0, scal_ff[sel_reg]} >> (32*sel_word));
          end
        end
        OFS_ADDR_BASE: rd_word = base_ff;
        OFS_ADDR_IDX:  rd_word = idx_ff;
        OFS_ADDR_OUT:  rd_word = addr_ff;
        default:       rd_hit  = 1'b0;
      endcase
    end
  end

  // Read channel: one outstanding read, answer next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_hit ? rd_word : ERR_DATA;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end
  // no extra state for the second extension; halves are
  // the two 64-bit words of each wide register; HAS_VEC2 has no
  // mode gating anywhere.
endmodule
`default_nettype wire

// ---- include/ssr_pkg.sv ----
// Package: register map, field layout and constants of the vector state file
package ssr_pkg;
  localparam int unsigned VEC_COUNT     = 8;
  localparam int unsigned WIDE_BITS     = 128;
  localparam int unsigned NARROW_BITS   = 64;
  localparam int unsigned SCALAR_BITS   = 80;
  localparam int unsigned WORD_BITS     = 32;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_VCSR      = 12'h008;
  localparam logic [11:0] OFS_FLAGS     = 12'h00C;
  localparam logic [11:0] OFS_IDQ_LEAF  = 12'h010;
  localparam logic [11:0] OFS_IDQ_D     = 12'h014;
  localparam logic [11:0] OFS_SEL       = 12'h018;
  localparam logic [11:0] OFS_DATA      = 12'h01C;
  localparam logic [11:0] OFS_ADDR_BASE = 12'h020;
  localparam logic [11:0] OFS_ADDR_IDX  = 12'h024;
  localparam logic [11:0] OFS_ADDR_OUT  = 12'h028;
  localparam logic [11:0] OFS_SHADOW    = 12'h100;
  // Control bits
  localparam int unsigned CTRL_SAVE     = 0;
  localparam int unsigned CTRL_RESTORE  = 1;
  localparam int unsigned CTRL_CMPUPD   = 2;
  // Data window select: bank field [5:4], register [2:0], word [1:0] at [9:8]
  localparam logic [1:0]  BANK_WIDE     = 2'h0;
  localparam logic [1:0]  BANK_SCALAR   = 2'h1;
  localparam logic [1:0]  BANK_SHADOW   = 2'h2;
  // Vector control/status fields
  localparam int unsigned VCSR_DAZ      = 6;
  localparam int unsigned VCSR_FTZ      = 15;
  localparam logic [31:0] VCSR_RESET    = 32'h0000_1F80;
  localparam logic [31:0] VCSR_MASK     = 32'h0000_FFFF;
  localparam logic [31:0] FLAGS_RESET   = 32'h0000_0002;
  localparam logic [31:0] FLAGS_CMP_MASK = 32'h0000_08D5;
  // Identification query
  localparam logic [31:0] IDQ_LEAF_FEAT = 32'h0000_0001;
  localparam int unsigned IDQ_FASTSAVE  = 24;
  localparam int unsigned IDQ_VEC1      = 25;
  localparam int unsigned IDQ_VEC2      = 26;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] ERR_DATA      = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  typedef enum logic [1:0] {SSR_IDLE, SSR_SAVE, SSR_RESTORE} ssr_state_type;
endpackage

// ---- verification/simd_state_register_file_test.sv ----
// Testbench: register-level sequences against the vector state file
`timescale 1ns/1ps
`default_nettype none
module simd_state_register_file_test;
  import ssr_pkg::*;
  logic aclk, aresetn, busy_ff;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [WIDE_BITS-1:0] scalar_op_ff;
  int fails = 0, tests_run = 0, cycles = 0;

  ssr_state_file uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scalar_op_ff, .busy_ff);
  ssr_core_model core (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard, far above the several hundred cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] wr_resp;
    core.wr(a, v, wr_resp);
    check(wr_resp, RESP_OKAY);
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    core.rd(a, d, r);
    check({r, d}, {RESP_OKAY, exp});
  endtask
  // Poll status until save or restore has finished
  task automatic idle();
    int n = 0;
    do begin
      core.rd(OFS_STATUS, d, r);
      n++;
    end while (d !== ZERO_WORD && n < 30);
    check(d, ZERO_WORD);
  endtask
  // Window select word: word, bank, register
  function automatic logic [31:0] sel(int g, logic [1:0] b, int w);
    return {22'h0, 2'(w), 2'h0, b, 1'b0, 3'(g)};
  endfunction
  // Distinct pattern per register word
  function automatic logic [31:0] pat(int i);
    return {16'hA55A, 8'h3C, 8'(i)};
  endfunction

  initial begin
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(OFS_VCSR, VCSR_RESET);
    rreg(OFS_FLAGS, FLAGS_RESET);
    wreg(OFS_IDQ_LEAF, IDQ_LEAF_FEAT);
    core.rd(OFS_IDQ_D, d, r);
    check(d[26:24], 3'h7);
    // Fill all wide registers, then read back every lane
    for (int i = 0; i < 32; i++) begin
      wreg(OFS_SEL, sel(i / 4, BANK_WIDE, i % 4));
      wreg(OFS_DATA, pat(i));
    end
    for (int i = 0; i < 32; i++) begin
      wreg(OFS_SEL, sel(i / 4, BANK_WIDE, i % 4));
      rreg(OFS_DATA, pat(i));
      if (i % 4 == 1) check(scalar_op_ff, {64'h0, pat(i), pat(i - 1)});
    end
    // Save with a slow master, spoil state, restore
    core.slow = 3;
    wreg(OFS_SEL, sel(5, BANK_SCALAR, 0));
    wreg(OFS_DATA, 32'h1234_5678);
    wreg(OFS_VCSR, 32'hFFFF_FFFF);
    rreg(OFS_VCSR, VCSR_MASK);
    wreg(OFS_VCSR, 32'h0000_8040);
    wreg(OFS_CTRL, 32'h0000_0001);
    check(busy_ff, 1'b1);
    idle();
    check(busy_ff, 1'b0);
    wreg(OFS_DATA, ZERO_WORD);
    wreg(OFS_VCSR, VCSR_RESET);
    wreg(OFS_SEL, sel(3, BANK_WIDE, 2));
    wreg(OFS_DATA, ZERO_WORD);
    wreg(OFS_CTRL, 32'h0000_0002);
    check(busy_ff, 1'b1);
    idle();
    check(busy_ff, 1'b0);
    rreg(OFS_DATA, pat(14));
    rreg(OFS_VCSR, 32'h0000_8040);
    wreg(OFS_SEL, sel(5, BANK_SCALAR, 0));
    rreg(OFS_DATA, 32'h1234_5678);
    core.slow = 0;
    // Compare: equal low halves set zero flag, unequal clear it
    for (int w = 0; w < 2; w++) begin
      wreg(OFS_SEL, sel(1, BANK_WIDE, w));
      wreg(OFS_DATA, pat(w));
    end
    wreg(OFS_CTRL, 32'h0000_0004);
    rreg(OFS_FLAGS, 32'h0000_0042);
    wreg(OFS_DATA, ZERO_WORD);
    wreg(OFS_CTRL, 32'h0000_0004);
    rreg(OFS_FLAGS, FLAGS_RESET);
    // Address from general registers only
    wreg(OFS_ADDR_BASE, 32'h1000_0F00);
    wreg(OFS_ADDR_IDX, 32'h0000_0123);
    rreg(OFS_ADDR_OUT, 32'h1000_1023);
    // Hole and read-only word are refused
    core.rd(12'h030, d, r);
    check({r, d}, {RESP_SLVERR, ERR_DATA});
    core.wr(OFS_IDQ_D, 32'h0000_0000, r);
    check(r, RESP_SLVERR);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- verification/ssr_core_model.sv ----
// Bus master standing in for the instruction pipeline
`timescale 1ns/1ps
`default_nettype none
module ssr_core_model (
  input  wire logic        aclk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  int slow = 0;  // Extra cycles before taking an answer
  // Idle master at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
  end
  // Write: both halves offered, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw = 0;
    bit w = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;  // Released lines do not keep old value
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (slow) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read: address held until taken, then wait for data
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (slow) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/ssr_monitor.sv ----
// Checker: bus handshakes and state-file timing at the top ports
`timescale 1ns/1ps
`default_nettype none
module ssr_monitor
  import ssr_pkg::*;
(
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic [11:0]                  s_axi_awaddr,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic [31:0]                  s_axi_wdata,
  input wire logic [3:0]                   s_axi_wstrb,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic [1:0]                   s_axi_bresp,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic [11:0]                  s_axi_araddr,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [31:0]                  s_axi_rdata,
  input wire logic [1:0]                   s_axi_rresp,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire logic [ssr_pkg::WIDE_BITS-1:0] scalar_op_ff,
  input wire logic                         busy_ff
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers hold until the master takes them
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  // Read answer one cycle after the address is taken
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_wr_closed: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("second write taken");
  // Both halves taken together: answer within the stated latency
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == ERR_DATA) else $error("error read not zero");
  a_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h030 |=> s_axi_rresp == RESP_SLVERR)
    else $error("hole answered okay");
  a_scalar_high: assert property (
    scalar_op_ff[WIDE_BITS-1:NARROW_BITS] == 64'h0)
    else $error("scalar operand high half set");
  // A save or restore walks all eight registers
  a_busy_span: assert property ($rose(busy_ff) |->
    busy_ff[*7] ##[1:3] !busy_ff) else $error("busy span wrong");

  c_save: cover property ($rose(busy_ff));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind ssr_state_file ssr_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .scalar_op_ff, .busy_ff);
`default_nettype wire
